/* File: cbp_map.svh */
// constants of the clocked serial block port: modes, clock selects, counts
// assumes the system clock is the high-frequency clock that feeds the divider
`ifndef CBP_MAP_SVH
`define CBP_MAP_SVH

// ==========================================================
// transfer mode field values
`define CBP_MODE_TX 2'h0
`define CBP_MODE_RX 2'h1

// ==========================================================
// clock select field values
`define CBP_SEL_D13 3'h0
`define CBP_SEL_D8 3'h1
`define CBP_SEL_D6 3'h2
`define CBP_SEL_D5 3'h3
`define CBP_SEL_D4 3'h4
`define CBP_SEL_D3 3'h5
`define CBP_SEL_D2 3'h6
`define CBP_SEL_EXT 3'h7

// ==========================================================
// half-period terminal counts (half period minus one, in system clocks)
`define CBP_HALF_D13 12'hFFF
`define CBP_HALF_D8 12'h07F
`define CBP_HALF_D6 12'h01F
`define CBP_HALF_D5 12'h00F
`define CBP_HALF_D4 12'h007
`define CBP_HALF_D3 12'h003
`define CBP_HALF_D2 12'h001

// ==========================================================
// bit order, bit counts, buffer, status reset value
`define CBP_DIR_MSB 1'h0
`define CBP_BIT_LAST 3'h7
`define CBP_BIT_SECOND 3'h1
`define CBP_MEM_DEPTH 32
`define CBP_STATUS_RST 6'h08

`endif

/* File: cbp_pkg.sv */
// types of the clocked serial block port
// assumes cbp_map.svh for numeric constants
package cbp_pkg;

  // ==========================================================
  // control and status carriers
  typedef struct packed {
    logic run_bit;
    logic abort_bit;
    logic [1:0] transfer_mode_field;
    logic bit_order_control;
    logic [2:0] clk_sel;
  } cbp_ctrl_t;

  typedef struct packed {
    logic busy_flag;
    logic shift_active_flag;
    logic transmit_buffer_empty_flag;
    logic receive_buffer_full_flag;
    logic transmit_error_flag;
    logic receive_error_flag;
  } cbp_status_t;

  // ==========================================================
  // engine states
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_shift = 3'b010,
    st_hold = 3'b100
  } cbp_state_t;

endpackage

/* File: cbp_buffer_mem.sv */
// block data buffer: 32 bytes, one write port, registered read port
// assumes the caller arbitrates writers
`timescale 1ns/100ps
`include "cbp_map.svh"
module cbp_buffer_mem (
  input wire logic clock,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_data_q
);
  import cbp_pkg::*;

  logic [7:0] mem [0:`CBP_MEM_DEPTH-1];
  logic [7:0] rd_data_d;

  always_comb begin
    rd_data_d = mem[rd_addr];
  end

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end
endmodule

/* File: cbp_clk_div.sv */
// internal serial clock divider: one tick per half period of the serial clock
// assumes the select is steady while enabled
`timescale 1ns/100ps
`include "cbp_map.svh"
module cbp_clk_div (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic [2:0] sel,
  output logic tick_q
);
  import cbp_pkg::*;

  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic [11:0] term;
  logic tick_d;

  always_comb begin
    case (sel)
      `CBP_SEL_D13: term = `CBP_HALF_D13;
      `CBP_SEL_D8: term = `CBP_HALF_D8;
      `CBP_SEL_D6: term = `CBP_HALF_D6;
      `CBP_SEL_D5: term = `CBP_HALF_D5;
      `CBP_SEL_D4: term = `CBP_HALF_D4;
      `CBP_SEL_D3: term = `CBP_HALF_D3;
      default: term = `CBP_HALF_D2;
    endcase
    tick_d = 1'b0;
    cnt_d = cnt_q + 12'h001;
    if (!enable) begin
      cnt_d = 12'h000;
    end else if (cnt_q >= term) begin
      cnt_d = 12'h000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= 12'h000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  chk_tick_spacing: assert property (@(posedge clock) disable iff (rst)
    tick_q |=> !tick_q) else $error("divider ticks closer than two cycles");
endmodule

/* File: cbp_port.sv */
// clocked serial block port: block transmit and receive of 1 to 32 bytes
// assumes ctrl, byte count, buffer strobes come from logic on this clock
`timescale 1ns/100ps
`include "cbp_map.svh"
module cbp_port (
  input wire logic clock,
  input wire logic rst,
  input cbp_pkg::cbp_ctrl_t ctrl,
  input wire logic [4:0] byte_count_field,
  input wire logic buf_wr_en,
  input wire logic [7:0] buf_wr_data,
  input wire logic buf_rd_en,
  output logic [7:0] buf_rd_data,
  output cbp_pkg::cbp_status_t port_status,
  output logic transfer_interrupt,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic si_in,
  output logic so_out
);
  import cbp_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic sck_s1_q, sck_s2_q, sck_s3_q, si_s1_q, si_s2_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
      si_s1_q <= 1'b0;
      si_s2_q <= 1'b0;
    end else begin
      sck_s1_q <= sck_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      si_s1_q <= si_in;
      si_s2_q <= si_s1_q;
    end
  end

  // ==========================================================
  // shift clock selection
  cbp_state_t state_q, state_d;
  cbp_status_t stat_q, stat_d;
  logic ext_clk, div_en, div_tick, phase_q, phase_d, oe_d;
  logic lead, trail;

  assign ext_clk = (ctrl.clk_sel == `CBP_SEL_EXT);
  assign div_en = (state_q == st_shift) && !ext_clk && !ctrl.abort_bit;

  cbp_clk_div u_div (
    .clock(clock),
    .rst(rst),
    .enable(div_en),
    .sel(ctrl.clk_sel),
    .tick_q(div_tick)
  );

  always_comb begin
    lead = ext_clk ? (sck_s3_q && !sck_s2_q) : (div_tick && phase_q);
    trail = ext_clk ? (!sck_s3_q && sck_s2_q) : (div_tick && !phase_q);
    phase_d = phase_q;
    if (!div_en) begin
      phase_d = 1'b1;
    end else if (div_tick) begin
      phase_d = !phase_q;
    end
    oe_d = !ext_clk;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_q <= 1'b1;
      sck_oe <= 1'b0;
    end else begin
      phase_q <= phase_d;
      sck_oe <= oe_d;
    end
  end
  assign sck_out = phase_q;

  // ==========================================================
  // buffer access
  logic [4:0] byte_q, byte_d, ptr_q, ptr_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, rx_next, tx_byte;
  logic mem_wr, eng_wr, tx_mode, rx_mode, last_byte, lead_bit, msb_bit;

  assign tx_mode = (ctrl.transfer_mode_field == `CBP_MODE_TX);
  assign rx_mode = (ctrl.transfer_mode_field == `CBP_MODE_RX);
  assign last_byte = (byte_q == byte_count_field);
  assign eng_wr = (state_q == st_shift) && trail && rx_mode && (bit_q == `CBP_BIT_LAST);
  assign mem_wr = eng_wr || (buf_wr_en && state_q == st_idle);

  cbp_buffer_mem u_mem (
    .clock(clock),
    .rst(rst),
    .wr_en(mem_wr),
    .wr_addr(eng_wr ? byte_q : ptr_q),
    .wr_data(eng_wr ? rx_next : buf_wr_data),
    .rd_addr((state_q == st_idle) ? ptr_q : byte_q),
    .rd_data_q(tx_byte)
  );
  assign buf_rd_data = tx_byte;

  always_comb begin
    msb_bit = tx_byte[3'h7 - bit_q];
    lead_bit = (ctrl.bit_order_control == `CBP_DIR_MSB) ? msb_bit : tx_byte[bit_q];
    rx_next = (ctrl.bit_order_control == `CBP_DIR_MSB) ? {sh_q[6:0], si_s2_q} :
      {si_s2_q, sh_q[7:1]};
  end

  // ==========================================================
  // transfer engine
  logic armed_q, armed_d, so_d, irq_d;

  always_comb begin
    state_d = state_q;
    stat_d = stat_q;
    byte_d = byte_q;
    bit_d = bit_q;
    ptr_d = ptr_q;
    sh_d = sh_q;
    so_d = so_out;
    irq_d = 1'b0;
    armed_d = armed_q || !ctrl.run_bit;
    case (state_q)
      st_idle: begin
        if (buf_wr_en) begin
          ptr_d = ptr_q + 5'h01;
          stat_d.transmit_buffer_empty_flag = 1'b0;
        end else if (buf_rd_en && stat_q.receive_buffer_full_flag) begin
          ptr_d = ptr_q + 5'h01;
          if (ptr_q == byte_count_field) begin
            // block fully read: next software write starts at entry 0
            ptr_d = 5'h00;
            stat_d.receive_buffer_full_flag = 1'b0;
          end
        end
        if (ctrl.run_bit && armed_q) begin
          state_d = st_shift;
          byte_d = 5'h00;
          bit_d = 3'h0;
          ptr_d = 5'h00;
          if (rx_mode) begin
            stat_d.receive_buffer_full_flag = 1'b0;
          end
        end
      end
      st_shift: begin
        if (lead && tx_mode) begin
          so_d = lead_bit;
          if (bit_q == `CBP_BIT_SECOND && last_byte) begin
            irq_d = 1'b1;
          end
        end
        if (trail) begin
          sh_d = rx_next;
          bit_d = bit_q + 3'h1;
          if (bit_q == `CBP_BIT_LAST) begin
            byte_d = byte_q + 5'h01;
            if (last_byte) begin
              if (tx_mode) begin
                stat_d.transmit_buffer_empty_flag = 1'b1;
              end else begin
                stat_d.receive_buffer_full_flag = 1'b1;
                irq_d = 1'b1;
              end
              state_d = ctrl.run_bit ? st_hold : st_idle;
            end else if (!ctrl.run_bit) begin
              state_d = st_idle;
            end
          end
        end
      end
      st_hold: begin
        if (!ctrl.run_bit) begin
          state_d = st_idle;
        end else if (ext_clk && tx_mode && lead) begin
          stat_d.transmit_error_flag = 1'b1;
          so_d = 1'b1;
        end else if (ext_clk && rx_mode && trail) begin
          bit_d = bit_q + 3'h1;
          if (bit_q == `CBP_BIT_LAST) begin
            stat_d.receive_error_flag = 1'b1;
          end
        end
      end
      default: state_d = st_idle;
    endcase
    if (ctrl.abort_bit) begin
      state_d = st_idle;
      stat_d = `CBP_STATUS_RST;
      armed_d = 1'b0;
      byte_d = 5'h00;
      bit_d = 3'h0;
      ptr_d = 5'h00;
      so_d = 1'b1;
      irq_d = 1'b0;
    end
    stat_d.busy_flag = (state_d != st_idle);
    stat_d.shift_active_flag = (state_d == st_shift);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= st_idle;
      stat_q <= `CBP_STATUS_RST;
      byte_q <= 5'h00;
      bit_q <= 3'h0;
      ptr_q <= 5'h00;
      sh_q <= 8'h00;
      so_out <= 1'b1;
      transfer_interrupt <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      state_q <= state_d;
      stat_q <= stat_d;
      byte_q <= byte_d;
      bit_q <= bit_d;
      ptr_q <= ptr_d;
      sh_q <= sh_d;
      so_out <= so_d;
      transfer_interrupt <= irq_d;
      armed_q <= armed_d;
    end
  end
  assign port_status = stat_q;

  // ==========================================================
  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  chk_idle_sck_high: assert property (state_q == st_idle && $past(state_q) == st_idle
    && !ext_clk |-> sck_out) else $error("internal clock pin not high while idle");
  chk_ext_no_drive: assert property (ext_clk && $past(ext_clk) |-> !sck_oe)
    else $error("clock pin driven with external clock");
  chk_abort_reset: assert property (ctrl.abort_bit |=> state_q == st_idle
    && stat_q == `CBP_STATUS_RST && so_out) else $error("abort did not reset");
  chk_tx_msb_order: assert property (state_q == st_shift && lead && tx_mode
    && !ctrl.abort_bit && ctrl.bit_order_control == `CBP_DIR_MSB |=> so_out == $past(msb_bit))
    else $error("msb-first bit wrong");
  chk_irq_second_bit: assert property (state_q == st_shift && lead && tx_mode
    && bit_q == `CBP_BIT_SECOND && last_byte && !ctrl.abort_bit |=> transfer_interrupt)
    else $error("interrupt missing at second bit");
  chk_stop_at_end: assert property (state_q == st_shift && trail && bit_q == `CBP_BIT_LAST
    && last_byte && !ctrl.run_bit && !ctrl.abort_bit |=> !stat_q.busy_flag)
    else $error("busy did not drop after last byte");
  chk_tx_error: assert property (state_q == st_hold && ext_clk && tx_mode && lead
    && ctrl.run_bit && !ctrl.abort_bit |=> stat_q.transmit_error_flag && so_out)
    else $error("transmit error not flagged");
  chk_err_sticky: assert property (stat_q.transmit_error_flag && !ctrl.abort_bit
    |=> stat_q.transmit_error_flag) else $error("error flag lost without abort");
  chk_start_busy: assert property (state_q == st_idle && ctrl.run_bit && armed_q
    && !ctrl.abort_bit |=> stat_q.busy_flag ##0 stat_q.shift_active_flag)
    else $error("run did not start transfer");
endmodule

/* File: cbp_far_dev.sv */
// far-side serial device: samples so on rising pin edges, shifts si out on falling ones
// assumes the bench loads its byte and asks for external clock pulses by task calls
`timescale 1ns/100ps
module cbp_far_dev (
  input wire logic clock,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic so_out,
  output logic sck_pin,
  output logic si_in
);
  logic ext_sck = 1'b1;
  logic pin_q = 1'b1;
  logic framed = 1'b0;
  logic si_q = 1'b0;
  logic [7:0] tx_sh = 8'h00;
  logic [31:0] cap = 32'h0;
  int tx_left = 0;
  int n_bits = 0;

  // ==========================================================
  // pin levels: ext_sck rests high, standing in for the pull-up
  assign sck_pin = sck_oe ? sck_out : ext_sck;
  assign si_in = si_q;

  task automatic load(input logic [7:0] b);
    tx_sh = b;
    tx_left = 8;
  endtask

  // phases of half system clocks each, never shorter than four
  task automatic pulses(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge clock);
      ext_sck <= 1'b0;
      repeat (half) @(posedge clock);
      ext_sck <= 1'b1;
    end
  endtask

  // ==========================================================
  // shifting; outside a frame si toggles so no stale bit is seen
  always @(posedge clock) begin
    pin_q <= sck_pin;
    if (pin_q && !sck_pin && tx_left > 0) begin
      si_q <= tx_sh[7];
      tx_sh <= {tx_sh[6:0], 1'b0};
      tx_left <= tx_left - 1;
      framed <= 1'b1;
    end else if (!framed) begin
      si_q <= ~si_q;
    end
    if (!pin_q && sck_pin) begin
      cap <= {cap[30:0], so_out};
      n_bits <= n_bits + 1;
      if (tx_left == 0) begin
        framed <= 1'b0;
      end
    end
  end
endmodule

/* File: cbp_port_tb.sv */
// self-checking bench for the clocked serial block port
// assumes the port, its package, its map header and the far-side model
`timescale 1ns/100ps
`include "cbp_map.svh"
module cbp_port_tb;
  import cbp_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  cbp_ctrl_t ctrl = '0;
  logic [4:0] byte_count_field = 5'h00;
  logic buf_wr_en = 1'b0;
  logic [7:0] buf_wr_data = 8'h00;
  logic buf_rd_en = 1'b0;
  logic [7:0] buf_rd_data;
  cbp_status_t port_status;
  logic transfer_interrupt;
  logic sck_pin, sck_out, sck_oe, si_in, so_out;
  int n_errors = 0;
  int n_compared = 0;
  int n_irq = 0;
  int irq_bits = 0;
  int cycles = 0;
  logic [31:0] exp_per [7] = '{32'h2000, 32'h100, 32'h40, 32'h20, 32'h10, 32'h8, 32'h4};

  cbp_port u_cbp_port (.clock(clock), .rst(rst), .ctrl(ctrl),
    .byte_count_field(byte_count_field), .buf_wr_en(buf_wr_en), .buf_wr_data(buf_wr_data),
    .buf_rd_en(buf_rd_en), .buf_rd_data(buf_rd_data), .port_status(port_status),
    .transfer_interrupt(transfer_interrupt), .sck_in(sck_pin), .sck_out(sck_out),
    .sck_oe(sck_oe), .si_in(si_in), .so_out(so_out));
  cbp_far_dev u_cbp_far_dev (.clock(clock), .sck_out(sck_out), .sck_oe(sck_oe),
    .so_out(so_out), .sck_pin(sck_pin), .si_in(si_in));

  // ==========================================================
  // clock, hang limit, interrupt monitor
  always #12.5 clock = ~clock;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      n_errors = n_errors + 1;
      results();
    end
  end

  always @(negedge clock) begin
    if (transfer_interrupt === 1'b1) begin
      n_irq = n_irq + 1;
      irq_bits = u_cbp_far_dev.n_bits;
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [7:0] ebyte(input int k);
    return 8'h21 + 8'(k * 19);
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int k = 0; k < 8; k++) rev8[k] = b[7 - k];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int b, input logic v);
    int i;
    for (i = 0; i < 30000 && port_status[b] !== v; i++) @(posedge clock);
    if (i == 30000) begin
      n_errors = n_errors + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, port_status, v);
    end
  endtask

  task automatic setup(input logic [1:0] m, input logic d, input logic [2:0] s,
                       input logic [4:0] c);
    ctrl <= '{1'b0, 1'b0, m, d, s};
    byte_count_field <= c;
    @(posedge clock);
  endtask

  task automatic wr_block(input int n);
    for (int k = 0; k < n; k++) begin
      buf_wr_en <= 1'b1;
      buf_wr_data <= ebyte(k);
      @(posedge clock);
    end
    buf_wr_en <= 1'b0;
  endtask

  task automatic go();
    u_cbp_far_dev.n_bits = 0;
    n_irq = 0;
    ctrl.run_bit <= 1'b1;
    @(posedge clock);
  endtask

  task automatic stop();
    ctrl.run_bit <= 1'b0;
    @(posedge clock);
  endtask

  task automatic abort();
    ctrl.abort_bit <= 1'b1;
    ctrl.run_bit <= 1'b0;
    @(posedge clock);
    ctrl.abort_bit <= 1'b0;
    @(posedge clock);
  endtask

  // full sck_out period in system clocks, falling edge to falling edge
  task automatic period(output int p);
    int i;
    for (i = 0; i < 9000 && sck_out !== 1'b0; i++) @(posedge clock);
    for (p = 0; p < 9000 && sck_out !== 1'b1; p++) @(posedge clock);
    for (i = 0; i < 9000 && sck_out !== 1'b0; i++) begin
      @(posedge clock);
      p = p + 1;
    end
  endtask

  task automatic results();
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    int p;
    int i;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check(32'(sck_out), 32'h1);
    // every internal divider, each aborted inside its first byte
    for (int s = 0; s < 7; s++) begin
      setup(`CBP_MODE_TX, `CBP_DIR_MSB, 3'(s), 5'h00);
      wr_block(1);
      go();
      period(p);
      check(32'(p), exp_per[s]);
      abort();
      check(32'(port_status), 32'(`CBP_STATUS_RST));
      check(32'(so_out), 32'h1);
    end
    // longest block, MSB first, run left high to the end
    setup(`CBP_MODE_TX, `CBP_DIR_MSB, `CBP_SEL_D6, 5'h1F);
    wr_block(32);
    go();
    wt(3, 1'b1);
    repeat (2) @(posedge clock);
    check(32'(n_irq), 32'h1);
    check(32'(irq_bits), 32'hF9);
    check(32'(u_cbp_far_dev.n_bits), 32'h100);
    check(u_cbp_far_dev.cap, {ebyte(28), ebyte(29), ebyte(30), ebyte(31)});
    stop();
    wt(5, 1'b0);
    check(32'(sck_out), 32'h1);
    // LSB first, run cleared at the interrupt
    setup(`CBP_MODE_TX, 1'b1, `CBP_SEL_D6, 5'h00);
    wr_block(1);
    go();
    for (i = 0; i < 3000 && n_irq == 0; i++) @(posedge clock);
    stop();
    check(32'(port_status.busy_flag), 32'h1);
    wt(5, 1'b0);
    repeat (2) @(posedge clock);
    check(32'(u_cbp_far_dev.n_bits), 32'h8);
    check(32'(u_cbp_far_dev.cap[7:0]), 32'(rev8(ebyte(0))));
    // receive in both bit orders
    for (int d = 0; d < 2; d++) begin
      setup(`CBP_MODE_RX, 1'(d), `CBP_SEL_D6, 5'h00);
      u_cbp_far_dev.load(8'hC6);
      go();
      wt(2, 1'b1);
      stop();
      wt(5, 1'b0);
      repeat (2) @(posedge clock);
      check(32'(buf_rd_data), d ? 32'h63 : 32'hC6);
      buf_rd_en <= 1'b1;
      @(posedge clock);
      buf_rd_en <= 1'b0;
      repeat (2) @(posedge clock);
      check(32'(port_status.receive_buffer_full_flag), 32'h0);
    end
    // external clock, one pulse too many
    setup(`CBP_MODE_TX, `CBP_DIR_MSB, `CBP_SEL_EXT, 5'h00);
    buf_wr_en <= 1'b1;
    buf_wr_data <= 8'h92;
    @(posedge clock);
    buf_wr_en <= 1'b0;
    go();
    repeat (8) @(posedge clock);
    check(32'(sck_oe), 32'h0);
    check(32'(port_status.shift_active_flag), 32'h1);
    check(32'(u_cbp_far_dev.n_bits), 32'h0);
    u_cbp_far_dev.pulses(8, 20);
    repeat (8) @(posedge clock);
    check(32'(u_cbp_far_dev.cap[7:0]), 32'h92);
    check(32'(port_status.transmit_error_flag), 32'h0);
    u_cbp_far_dev.pulses(1, 20);
    repeat (8) @(posedge clock);
    check(32'(port_status.transmit_error_flag), 32'h1);
    check(32'(so_out), 32'h1);
    stop();
    wt(5, 1'b0);
    check(32'(port_status.transmit_error_flag), 32'h1);
    abort();
    check(32'(port_status), 32'(`CBP_STATUS_RST));
    results();
  end
endmodule
